// [rtl/tlrs_defines.vh]
`ifndef TLRS_DEFINES_VH
`define TLRS_DEFINES_VH
// clock rate in MHz (50 ns period)
`define TLRS_CLK_MHZ          16'h0014
// clock period in ns
`define TLRS_CLK_NS           16'h0032
// pll lock limit after power-down release, microseconds
`define TLRS_T_PLL_LOCK_US    16'h004b
`define TLRS_PLL_LOCK_CYC     (`TLRS_T_PLL_LOCK_US * `TLRS_CLK_MHZ)
// least reference-lock hold after analog reset release, microseconds
`define TLRS_T_REF_HOLD_US    16'h000f
`define TLRS_REF_HOLD_CYC     (`TLRS_T_REF_HOLD_US * `TLRS_CLK_MHZ)
// longest valid-data wait after data lock or frequency lock, ns
`define TLRS_T_DATA_NS        16'h0fa0
// divided by the period so that no product overflows the counter width
`define TLRS_DATA_CYC         (`TLRS_T_DATA_NS / `TLRS_CLK_NS)
// offset cancellation budget in reconfiguration-clock cycles
`define TLRS_OFFSET_CYC       16'h4268
// least digital reset width in parallel-clock cycles
`define TLRS_DRST_CYC         2'h2
// counter width
`define TLRS_CNT_W            16
`endif

// [rtl/tlrs_seq.v]
`timescale 1ns/1ps
`include "tlrs_defines.vh"
module tlrs_seq #(
  parameter OFFSET_CYC = `TLRS_OFFSET_CYC
) (
  input  wire clock,
  input  wire resetn,
  input  wire start,
  input  wire manual_mode,
  input  wire oversample_mode,
  input  wire pll_locked_pin,
  input  wire freq_locked_pin,
  input  wire offset_tick,
  output reg  pll_powerdown_q,
  output reg  rx_analog_reset_q,
  output reg  rx_digital_reset_q,
  output reg  ref_lock_mode_q,
  output reg  data_lock_req_q,
  output reg  ready_q,
  output reg  lock_fail_q
);
  // one-hot states
  localparam S_IDLE   = 7'b0000001;
  localparam S_OFFSET = 7'b0000010;
  localparam S_PLL    = 7'b0000100;
  localparam S_REF    = 7'b0001000;
  localparam S_WLOCK  = 7'b0010000;
  localparam S_DATA   = 7'b0100000;
  localparam S_DONE   = 7'b1000000;

  // wait limits, cut to the counter width on purpose
  localparam [`TLRS_CNT_W-1:0] LIM_OFFSET = OFFSET_CYC[`TLRS_CNT_W-1:0]; // offset ticks
  localparam [`TLRS_CNT_W-1:0] LIM_PLL    = `TLRS_PLL_LOCK_CYC;           // pll lock clocks
  localparam [`TLRS_CNT_W-1:0] LIM_REF    = `TLRS_REF_HOLD_CYC;           // reference hold
  localparam [`TLRS_CNT_W-1:0] LIM_DATA   = `TLRS_DATA_CYC;               // valid-data wait

  // sequencer state and counters
  reg [6:0]             state_q;   // sequencer state
  reg [`TLRS_CNT_W-1:0] cnt_q;     // shared wait counter
  reg [1:0]             pll_sync_q; // pll lock synchroniser
  reg [1:0]             frq_sync_q; // frequency lock synchroniser
  reg [1:0]             tck_sync_q; // reconfig tick toggle synchroniser
  reg                   tck_prev_q; // last synchronised tick level
  reg [1:0]             drst_q;    // digital reset width counter

  // synchronised views of the pins
  wire                  pll_ok;    // synchronised pll lock
  wire                  frq_ok;    // synchronised frequency lock
  wire                  tck_ev;    // one reconfig cycle seen

  assign pll_ok = pll_sync_q[1];
  assign frq_ok = frq_sync_q[1];
  assign tck_ev = tck_sync_q[1] ^ tck_prev_q;

  // cycles reached test, reused by every timed wait (not the frequency-lock wait)
  // counts start at zero, so the limit is compared one below and the
  // state change lands exactly lim cycles after the wait began
  function reached;
    input [`TLRS_CNT_W-1:0] c;
    input [`TLRS_CNT_W-1:0] lim;
    begin
      reached = (c >= lim - 16'h0001);
    end
  endfunction

  // synchronisers for pins from outside the clock domain
  // offset_tick is a toggle: each edge stands for one reconfiguration cycle,
  // so its edges must lie at least two clocks apart to be counted;
  // only the second flop of each pair feeds the logic
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pll_sync_q <= 2'h0;
      frq_sync_q <= 2'h0;
      tck_sync_q <= 2'h0;
      tck_prev_q <= 1'b0;
    end else begin
      pll_sync_q <= {pll_sync_q[0], pll_locked_pin};
      frq_sync_q <= {frq_sync_q[0], freq_locked_pin};
      tck_sync_q <= {tck_sync_q[0], offset_tick};
      tck_prev_q <= tck_sync_q[1];
    end
  end

  // sequencer: offset cancel, pll lock, reference hold, data lock, valid wait
  // offset cancellation runs first, while the pll is still powered down;
  // a lock failure parks the channel in idle, powered down, until start;
  // ready only rises once the valid-data wait and the reset width are met;
  // the failure flag stays until the next start so software can read it
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      // channel fully in reset, pll powered down
      state_q            <= S_IDLE;
      cnt_q              <= 16'h0000;
      drst_q             <= 2'h0;
      pll_powerdown_q    <= 1'b1;
      rx_analog_reset_q  <= 1'b1;
      rx_digital_reset_q <= 1'b1;
      ref_lock_mode_q    <= 1'b1;
      data_lock_req_q    <= 1'b0;
      ready_q            <= 1'b0;
      lock_fail_q        <= 1'b0;
    end else begin
      // count held reset cycles for the minimum width
      // (saturates at three, which already meets the two-cycle minimum)
      if (rx_digital_reset_q && drst_q != 2'h3) begin
        drst_q <= drst_q + 2'h1;
      end
      case (state_q)
        S_IDLE: begin
          // a new run clears the previous failure
          if (start) begin
            state_q     <= S_OFFSET;
            cnt_q       <= 16'h0000;
            lock_fail_q <= 1'b0;
          end
        end

        // count reconfig cycles while offsets cancel
        S_OFFSET: begin
          if (tck_ev) begin
            cnt_q <= cnt_q + 16'h0001;
            // the last tick releases the pll power-down
            if (reached(cnt_q, LIM_OFFSET)) begin
              state_q         <= S_PLL;
              cnt_q           <= 16'h0000;
              pll_powerdown_q <= 1'b0;
            end
          end
        end

        // await pll lock, fail when limit passes
        S_PLL: begin
          cnt_q <= cnt_q + 16'h0001;
          // lock seen: release the receive analog reset
          if (pll_ok) begin
            state_q           <= S_REF;
            cnt_q             <= 16'h0000;
            rx_analog_reset_q <= 1'b0;
          end else if (reached(cnt_q, LIM_PLL)) begin
            // no lock in time: power down and report failure
            state_q         <= S_IDLE;
            lock_fail_q     <= 1'b1;
            pll_powerdown_q <= 1'b1;
          end
        end

        // hold reference lock before data lock
        S_REF: begin
          // still inside the reference-lock hold
          if (!reached(cnt_q, LIM_REF)) begin
            cnt_q <= cnt_q + 16'h0001;
          end else if (oversample_mode) begin
            // oversampling never leaves reference lock
            state_q <= S_REF;
          end else if (manual_mode) begin
            // manual: request data lock from the fabric side
            state_q         <= S_DATA;
            cnt_q           <= 16'h0000;
            ref_lock_mode_q <= 1'b0;
            data_lock_req_q <= 1'b1;
          end else begin
            // automatic: the recovery circuit finds frequency lock itself
            state_q         <= S_WLOCK;
            ref_lock_mode_q <= 1'b0;
          end
        end

        // automatic mode: wait for frequency lock
        S_WLOCK: begin
          if (frq_ok) begin
            // synchronised frequency lock starts the data wait
            state_q <= S_DATA;
            cnt_q   <= 16'h0000;
          end
        end

        // valid-data wait, then release digital reset
        S_DATA: begin
          cnt_q <= cnt_q + 16'h0001;
          // wait expired and reset wide enough: release the channel
          if (reached(cnt_q, LIM_DATA) && drst_q >= `TLRS_DRST_CYC) begin
            state_q            <= S_DONE;
            rx_digital_reset_q <= 1'b0;
            ready_q            <= 1'b1;
          end
        end

        // running; start restarts the sequence
        S_DONE: begin
          if (start) begin
            // full restart puts the channel back in reset
            state_q            <= S_OFFSET;
            cnt_q              <= 16'h0000;
            drst_q             <= 2'h0;
            pll_powerdown_q    <= 1'b1;
            rx_analog_reset_q  <= 1'b1;
            rx_digital_reset_q <= 1'b1;
            ref_lock_mode_q    <= 1'b1;
            data_lock_req_q    <= 1'b0;
            ready_q            <= 1'b0;
          end
        end

        default: begin
          // unreachable codes recover to idle
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// [verification/tlrs_pll_cdr_model.sv]
`timescale 1ns/1ps
module tlrs_pll_cdr_model (
  input  wire        clock,
  input  wire        pll_powerdown_q,
  input  wire        ref_lock_mode_q,
  input  wire        manual_mode,
  input  wire        pll_dead,
  input  wire [10:0] lock_dly,
  output reg         pll_locked_pin,
  output reg         freq_locked_pin,
  output reg         offset_tick
);
  integer n; // cycles since power-down release
  initial begin
    pll_locked_pin = 1'b0;
    freq_locked_pin = 1'b0;
    offset_tick = 1'b0;
    n = 0;
  end
  // free reconfiguration clock, unrelated in phase to clock; the receiver is
  // in use, so its cycles stand for a fast reconfiguration clock, counted
  // here as toggles spaced widely enough for the sequencer to see each one
  always #130 offset_tick = ~offset_tick;
  // pll locks a set delay after power-down release, never when dead
  always @(posedge clock) begin
    if (pll_powerdown_q) begin
      n <= 0;
      pll_locked_pin <= 1'b0;
    end else begin
      n <= n + 1;
      if (n == lock_dly && !pll_dead) pll_locked_pin <= 1'b1;
    end
  end
  // frequency lock once out of reference lock, automatic mode only
  always @(posedge clock) freq_locked_pin <= !manual_mode && !ref_lock_mode_q && !pll_powerdown_q;
endmodule

// [verification/tlrs_seq_chk.sv]
`timescale 1ns/1ps
module tlrs_seq_chk (
  input wire clock,
  input wire resetn,
  input wire start,
  input wire manual_mode,
  input wire oversample_mode,
  input wire pll_locked_pin,
  input wire freq_locked_pin,
  input wire offset_tick,
  input wire pll_powerdown_q,
  input wire rx_analog_reset_q,
  input wire rx_digital_reset_q,
  input wire ref_lock_mode_q,
  input wire data_lock_req_q,
  input wire ready_q,
  input wire lock_fail_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // reference lock kept the whole hold time, then left promptly
  a_ref_hold: assert property (
    $fell(rx_analog_reset_q) && !oversample_mode |->
    ##299 ref_lock_mode_q ##1 !ref_lock_mode_q) else $error("ref lock hold wrong");
  // digital reset kept through the valid-data wait after a data-lock request
  a_manual_wait: assert property (
    $rose(data_lock_req_q) |-> ##79 rx_digital_reset_q ##1 (ready_q && !rx_digital_reset_q))
    else $error("manual data wait wrong");
  // same wait counted from frequency lock in automatic mode
  a_auto_wait: assert property (
    $rose(freq_locked_pin) |-> ##78 !ready_q ##[1:8] ready_q) else $error("auto data wait wrong");
  // digital reset never a single-cycle glitch
  a_drst_width: assert property (
    $rose(rx_digital_reset_q) |=> rx_digital_reset_q) else $error("digital reset too short");
  // data lock only once out of reference lock and never when oversampling
  a_data_gate: assert property (
    data_lock_req_q |-> !ref_lock_mode_q && !oversample_mode) else $error("data lock illegal");
  // oversampling never completes
  a_os_park: assert property (
    $rose(ready_q) |-> !oversample_mode) else $error("ready while oversampling");
  // analog reset released only with the pll powered
  a_pll_order: assert property (
    !rx_analog_reset_q |-> !pll_powerdown_q) else $error("analog release before pll");
  // a lock failure leaves the channel powered down and in reset
  a_fail_safe: assert property (
    $rose(lock_fail_q) |-> pll_powerdown_q && rx_analog_reset_q) else $error("fail not safe");
  // ready only with digital reset released and reference lock left
  a_ready_out: assert property (
    ready_q |-> !rx_digital_reset_q && !ref_lock_mode_q) else $error("ready with reset");
  // clocks since power-down release, saturating
  logic [11:0] pd_low_cnt;
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pd_low_cnt <= 12'h000;
    end else if (pll_powerdown_q) begin
      pd_low_cnt <= 12'h000;
    end else if (pd_low_cnt != 12'hfff) begin
      pd_low_cnt <= pd_low_cnt + 12'h001;
    end
  end
  // a lock failure comes exactly at the end of the 75 us lock wait
  a_pll_limit: assert property (
    $rose(lock_fail_q) |-> pd_low_cnt == 12'h5dc) else $error("pll lock limit wrong");
endmodule
bind tlrs_seq tlrs_seq_chk u_chk (.clock, .resetn, .start, .manual_mode, .oversample_mode,
  .pll_locked_pin, .freq_locked_pin, .offset_tick, .pll_powerdown_q, .rx_analog_reset_q,
  .rx_digital_reset_q, .ref_lock_mode_q, .data_lock_req_q, .ready_q, .lock_fail_q);

// [verification/tlrs_seq_tb_top.sv]
`timescale 1ns/1ps
module tlrs_seq_tb_top;
  reg         clock, resetn, start, manual_mode, oversample_mode, pll_dead;
  reg  [10:0] lock_dly;
  wire        pll_locked_pin, freq_locked_pin, offset_tick, pll_powerdown_q, rx_analog_reset_q;
  wire        rx_digital_reset_q, ref_lock_mode_q, data_lock_req_q, ready_q, lock_fail_q;
  wire [6:0]  st = {pll_powerdown_q, rx_analog_reset_q, rx_digital_reset_q,
                    ref_lock_mode_q, data_lock_req_q, ready_q, lock_fail_q};
  integer     n_errors, n_tests, i;
  tlrs_seq #(.OFFSET_CYC(20)) u_dut (.clock, .resetn, .start, .manual_mode, .oversample_mode,
    .pll_locked_pin, .freq_locked_pin, .offset_tick, .pll_powerdown_q, .rx_analog_reset_q,
    .rx_digital_reset_q, .ref_lock_mode_q, .data_lock_req_q, .ready_q, .lock_fail_q);
  tlrs_pll_cdr_model u_model (.clock, .pll_powerdown_q, .ref_lock_mode_q, .manual_mode,
    .pll_dead, .lock_dly, .pll_locked_pin, .freq_locked_pin, .offset_tick);
  // compare the packed output state
  task chk(input [6:0] got, input [6:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // one start pulse, then wait for ready or failure under a bound
  task run(input m, input os, input dead, input [10:0] dly);
    begin
      start = 1'b1;
      @(posedge clock);
      #5 start = 1'b0;
      // modes change only once the sequencer has restarted, so a live
      // channel never sees its lock mode switched under it
      manual_mode = m;
      oversample_mode = os;
      pll_dead = dead;
      lock_dly = dly;
      // outputs are looked at 5 ns after each edge, once settled
      for (i = 0; i < 4000 && ready_q !== 1'b1 && lock_fail_q !== 1'b1; i = i + 1) begin
        @(posedge clock);
        #5;
      end
    end
  endtask
  task wrap_up;
    begin
      $display("errors=%0d tests=%0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // watchdog well beyond the longest sequence set
  initial begin
    #1000000;
    n_errors = n_errors + 1;
    wrap_up;
  end
  initial begin
    n_errors = 0;
    n_tests = 0;
    {resetn, start, manual_mode, oversample_mode, pll_dead} = 5'h04;
    lock_dly = 11'h005;
    repeat (16) @(posedge clock);
    #5 resetn = 1'b1;
    chk(st, 7'h78);
    run(1'b1, 1'b0, 1'b0, 11'h005);
    chk(st, 7'h06);
    run(1'b0, 1'b0, 1'b0, 11'h4b0);
    chk(st, 7'h02);
    run(1'b1, 1'b0, 1'b1, 11'h005);
    chk(st, 7'h79);
    run(1'b1, 1'b1, 1'b0, 11'h005);
    chk(st, 7'h18);
    wrap_up;
  end
endmodule
